// ---- logic/dccd_pkg.sv ----
`default_nettype none
package dccd_pkg;
	localparam int DCCD_DECADES = 6;
	localparam int DCCD_DIGIT_W = 4;
	localparam int DCCD_COUNT_W = 24;
	localparam int DCCD_LATCH_W = 25;
	localparam int DCCD_LATCH_OVF_BIT = 24;
	localparam int DCCD_DOT_W = 10;
	localparam int DCCD_SEL_W = 3;
	localparam int DCCD_PIN_W = 11;
	localparam int DCCD_ADDR_W = 4;
	localparam int DCCD_DATA_W = 32;
	localparam int DCCD_ST_W = 3;

	// digit select codes
	localparam logic [2:0] DCCD_SEL_LSD = 3'h6;
	localparam logic [2:0] DCCD_SEL_MSD = 3'h5;
	localparam logic [2:0] DCCD_SEL_EXT = 3'h7;
	localparam logic [2:0] DCCD_IDX_LSD = 3'h0;

	// decade values
	localparam logic [3:0] DCCD_BCD_MAX = 4'h9;
	localparam logic [3:0] DCCD_BCD_ZERO = 4'h0;
	localparam logic [3:0] DCCD_BCD_ONE = 4'h1;
	localparam logic [3:0] DCCD_BUS_RELEASE = 4'hF;
	localparam logic [2:0] DCCD_NEAR_DECADE = 3'h4;
	localparam logic [3:0] DCCD_NEAR_DIGIT = 4'h9;

	// decoder input codes
	localparam logic [3:0] DCCD_CODE_MINUS = 4'hC;

	// register offsets (byte addresses)
	localparam logic [3:0] DCCD_REG_STATUS = 4'h0;
	localparam logic [3:0] DCCD_REG_MASK = 4'h4;
	localparam logic [3:0] DCCD_REG_LATCH = 4'h8;
	localparam logic [3:0] DCCD_REG_CTRL = 4'hC;

	// field positions
	localparam int DCCD_ST_OVF = 0;
	localparam int DCCD_ST_NEAR = 1;
	localparam int DCCD_ST_XFER = 2;
	localparam int DCCD_CTRL_CLR = 0;

	// values after reset
	localparam logic [23:0] DCCD_COUNT_RST = 24'h000000;
	localparam logic [24:0] DCCD_LATCH_RST = 25'h0000000;
	localparam logic [2:0] DCCD_STATUS_RST = 3'h0;
	localparam logic [2:0] DCCD_MASK_RST = 3'h0;
	localparam logic [3:0] DCCD_BCD_OUT_RST = 4'h0;
	localparam logic [9:0] DCCD_DOTS_RST = 10'h000;
	// transfer pin idles high; a low reset value would fake a transfer edge
	localparam logic [10:0] DCCD_PIN_RST = 11'h002;
	localparam logic [31:0] DCCD_RDATA_RST = 32'h00000000;
endpackage
`default_nettype wire

// ---- logic/dccd_char_rom.sv ----
`timescale 1ns/1ps
`default_nettype none
module dccd_char_rom
	import dccd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [3:0] code,
	input wire logic right_half,
	output logic [9:0] dots
);
	// bit n drives dot line n+1
	localparam logic [9:0] DOTS_ZERO = 10'h1DE;
	localparam logic [9:0] DOTS_EIGHT = 10'h1EE;
	localparam logic [9:0] DOTS_MINUS = 10'h030;
	localparam logic [9:0] DOTS_BLANK = 10'h000;

	logic [9:0] dots_ff;
	logic [9:0] nxt_dots;

	always_comb
	begin
		nxt_dots = DOTS_BLANK;
		case ({code, right_half})
			5'h00, 5'h01: nxt_dots = DOTS_ZERO;
			5'h02: nxt_dots = 10'h000;
			5'h03: nxt_dots = 10'h2DD;
			5'h04: nxt_dots = 10'h3E3;
			5'h05: nxt_dots = 10'h32E;
			5'h06: nxt_dots = 10'h323;
			5'h07: nxt_dots = 10'h2EE;
			5'h08: nxt_dots = 10'h03D;
			5'h09: nxt_dots = 10'h2FC;
			5'h0A: nxt_dots = 10'h33F;
			5'h0B: nxt_dots = 10'h1E3;
			5'h0C: nxt_dots = 10'h1FE;
			5'h0D: nxt_dots = 10'h1E2;
			5'h0E: nxt_dots = 10'h003;
			5'h0F: nxt_dots = 10'h2DF;
			5'h10, 5'h11: nxt_dots = DOTS_EIGHT;
			5'h12: nxt_dots = 10'h12E;
			5'h13: nxt_dots = 10'h1FE;
			{DCCD_CODE_MINUS, 1'b0}, {DCCD_CODE_MINUS, 1'b1}: nxt_dots = DOTS_MINUS;
			default: nxt_dots = DOTS_BLANK;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			dots_ff <= DCCD_DOTS_RST;
		else
			dots_ff <= nxt_dots;
	end

	assign dots = dots_ff;
endmodule
`default_nettype wire

// ---- logic/dccd_top.sv ----
// Behaviour
// - six decades, overflow, 25-bit latch, digit mux
// - decades count zero through 999999
// - count on rising input edge only
// - latch follows while transfer low, holds high
// - high reset clears all decades
// - overflow set; output rises after transfer
// - one decade at a time, 4-bit positive BCD
// - select 6 gives LSD, 5 gives MSD
// - select 7 drives all data lines high
// - near-full flag low after 90,000 counts
// - decoder turns code and half into dots
// - BCD weights; 0/8 symmetric, minus, blank
// - half bit high while right half driven
`timescale 1ns/1ps
`default_nettype none
module dccd_top
	import dccd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic count_in,
	input wire logic transfer_n,
	input wire logic reset_in,
	input wire logic [2:0] digit_sel,
	input wire logic [3:0] char_code,
	input wire logic char_right,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic [3:0] bcd_out,
	output logic overflow_out,
	output logic near_full_n,
	output logic [9:0] dots,
	output logic irq
);
	function automatic logic [3:0] dccd_digit(input logic [23:0] v, input logic [2:0] idx);
		dccd_digit = v[4 * int'(idx) +: 4];
	endfunction

	// select code to decade index; 0 and 6 both address the lowest
	function automatic logic [2:0] dccd_sel_idx(input logic [2:0] sel);
		if (sel == DCCD_SEL_LSD)
			dccd_sel_idx = DCCD_IDX_LSD;
		else
			dccd_sel_idx = sel;
	endfunction

	// ripple BCD increment; bit 24 is the carry out of the top decade
	function automatic logic [24:0] dccd_bcd_inc(input logic [23:0] v);
		logic [24:0] r;
		logic c;
		logic [3:0] d;
		r = DCCD_LATCH_RST;
		c = 1'b1;
		for (int i = 0; i < DCCD_DECADES; i++)
		begin
			d = v[4 * i +: 4];
			if (c && d == DCCD_BCD_MAX)
				r[4 * i +: 4] = DCCD_BCD_ZERO;
			else if (c)
			begin
				r[4 * i +: 4] = d + DCCD_BCD_ONE;
				c = 1'b0;
			end
			else
				r[4 * i +: 4] = d;
		end
		r[DCCD_LATCH_OVF_BIT] = c;
		dccd_bcd_inc = r;
	endfunction

	// pin synchronisers
	logic [10:0] pin_s1_ff;
	logic [10:0] pin_s2_ff;
	logic [10:0] nxt_pin_s1;
	logic [10:0] nxt_pin_s2;
	logic cnt_prev_ff;
	logic xfer_prev_ff;
	logic nxt_cnt_prev;
	logic nxt_xfer_prev;
	logic cnt_s;
	logic xfer_n_s;
	logic rst_s;
	logic [2:0] sel_s;
	logic [3:0] code_s;
	logic right_s;
	logic cnt_rise;
	logic xfer_fall;

	always_comb
	begin
		nxt_pin_s1 = {char_right, char_code, digit_sel, reset_in, transfer_n, count_in};
		nxt_pin_s2 = pin_s1_ff;
		nxt_cnt_prev = cnt_s;
		nxt_xfer_prev = xfer_n_s;
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pin_s1_ff <= DCCD_PIN_RST;
			pin_s2_ff <= DCCD_PIN_RST;
			cnt_prev_ff <= 1'b0;
			xfer_prev_ff <= 1'b1;
		end
		else
		begin
			pin_s1_ff <= nxt_pin_s1;
			pin_s2_ff <= nxt_pin_s2;
			cnt_prev_ff <= nxt_cnt_prev;
			xfer_prev_ff <= nxt_xfer_prev;
		end
	end

	assign cnt_s = pin_s2_ff[0];
	assign xfer_n_s = pin_s2_ff[1];
	assign rst_s = pin_s2_ff[2];
	assign sel_s = pin_s2_ff[5:3];
	assign code_s = pin_s2_ff[9:6];
	assign right_s = pin_s2_ff[10];
	assign cnt_rise = cnt_s & ~cnt_prev_ff;
	assign xfer_fall = ~xfer_n_s & xfer_prev_ff;

	// register port decode
	logic [2:0] status_ff;
	logic [2:0] mask_ff;
	logic [31:0] rdata_ff;
	logic irq_ff;
	logic [2:0] nxt_status;
	logic [2:0] nxt_mask;
	logic [31:0] nxt_rdata;
	logic nxt_irq;
	logic sw_clr;
	logic [2:0] events;

	assign sw_clr = reg_wr && reg_addr == DCCD_REG_CTRL && reg_wdata[DCCD_CTRL_CLR];

	// counting core
	logic [23:0] count_ff;
	logic ovf_ff;
	logic near_ff;
	logic [23:0] nxt_count;
	logic nxt_ovf;
	logic nxt_near;
	logic ovf_evt;
	logic near_evt;
	logic [24:0] inc;

	always_comb
	begin
		nxt_count = count_ff;
		nxt_ovf = ovf_ff;
		nxt_near = near_ff;
		ovf_evt = 1'b0;
		near_evt = 1'b0;
		inc = dccd_bcd_inc(count_ff);
		if (rst_s || sw_clr)
		begin
			nxt_count = DCCD_COUNT_RST;
			nxt_ovf = 1'b0;
			nxt_near = 1'b0;
		end
		else if (cnt_rise)
		begin
			nxt_count = inc[23:0];
			if (inc[DCCD_LATCH_OVF_BIT] && !ovf_ff)
			begin
				nxt_ovf = 1'b1;
				ovf_evt = 1'b1;
			end
			if (dccd_digit(inc[23:0], DCCD_NEAR_DECADE) == DCCD_NEAR_DIGIT && !near_ff)
			begin
				nxt_near = 1'b1;
				near_evt = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			count_ff <= DCCD_COUNT_RST;
			ovf_ff <= 1'b0;
			near_ff <= 1'b0;
		end
		else
		begin
			count_ff <= nxt_count;
			ovf_ff <= nxt_ovf;
			near_ff <= nxt_near;
		end
	end

	// transfer latch and digit output
	logic [24:0] latch_ff;
	logic [3:0] bcd_ff;
	logic ovf_out_ff;
	logic near_n_ff;
	logic [24:0] nxt_latch;
	logic [3:0] nxt_bcd;
	logic nxt_ovf_out;
	logic nxt_near_n;

	always_comb
	begin
		nxt_latch = latch_ff;
		if (!xfer_n_s)
			nxt_latch = {ovf_ff, count_ff};
		if (sel_s == DCCD_SEL_EXT)
			nxt_bcd = DCCD_BUS_RELEASE;
		else
			nxt_bcd = dccd_digit(latch_ff[23:0], dccd_sel_idx(sel_s));
		nxt_ovf_out = latch_ff[DCCD_LATCH_OVF_BIT];
		nxt_near_n = ~near_ff;
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			latch_ff <= DCCD_LATCH_RST;
			bcd_ff <= DCCD_BCD_OUT_RST;
			ovf_out_ff <= 1'b0;
			near_n_ff <= 1'b1;
		end
		else
		begin
			latch_ff <= nxt_latch;
			bcd_ff <= nxt_bcd;
			ovf_out_ff <= nxt_ovf_out;
			near_n_ff <= nxt_near_n;
		end
	end

	// status, mask, interrupt, read data
	assign events = {xfer_fall, near_evt, ovf_evt};

	always_comb
	begin
		nxt_status = status_ff;
		nxt_mask = mask_ff;
		nxt_rdata = DCCD_RDATA_RST;
		if (reg_rd)
		begin
			case (reg_addr)
				DCCD_REG_STATUS:
				begin
					nxt_rdata = 32'(status_ff);
					nxt_status = DCCD_STATUS_RST;
				end
				DCCD_REG_MASK: nxt_rdata = 32'(mask_ff);
				DCCD_REG_LATCH: nxt_rdata = 32'(latch_ff);
				default: nxt_rdata = DCCD_RDATA_RST;
			endcase
		end
		if (reg_wr && reg_addr == DCCD_REG_MASK)
			nxt_mask = reg_wdata[2:0];
		// a new event wins over the read clear
		nxt_status = nxt_status | events;
		nxt_irq = |(nxt_status & nxt_mask);
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			status_ff <= DCCD_STATUS_RST;
			mask_ff <= DCCD_MASK_RST;
			rdata_ff <= DCCD_RDATA_RST;
			irq_ff <= 1'b0;
		end
		else
		begin
			status_ff <= nxt_status;
			mask_ff <= nxt_mask;
			rdata_ff <= nxt_rdata;
			irq_ff <= nxt_irq;
		end
	end

	// dot pattern for the half digit on the shared data lines
	dccd_char_rom u_rom
	(
		.ref_clk(ref_clk),
		.rstn(rstn),
		.code(code_s),
		.right_half(right_s),
		.dots(dots)
	);

	assign reg_rdata = rdata_ff;
	assign bcd_out = bcd_ff;
	assign overflow_out = ovf_out_ff;
	assign near_full_n = near_n_ff;
	assign irq = irq_ff;
endmodule
`default_nettype wire

// ---- verification/dccd_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module dccd_monitor
	import dccd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic transfer_n,
	input wire logic reset_in,
	input wire logic [2:0] digit_sel,
	input wire logic [3:0] char_code,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [3:0] bcd_out,
	input wire logic overflow_out,
	input wire logic near_full_n,
	input wire logic [9:0] dots
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	sequence sel_ext_s;
		(digit_sel == DCCD_SEL_EXT) [*4];
	endsequence
	sequence held_s;
		(transfer_n && $stable(digit_sel)) [*5];
	endsequence
	sel_release_a: assert property (sel_ext_s |-> bcd_out == DCCD_BUS_RELEASE)
		else $error("data lines not released");
	latch_hold_a: assert property (held_s |-> $stable(bcd_out))
		else $error("held digit moved");
	ovf_hold_a: assert property (transfer_n [*5] |-> $stable(overflow_out))
		else $error("overflow moved while held");
	ovf_xfer_a: assert property ($rose(overflow_out) |->
		!($past(transfer_n, 3) && $past(transfer_n, 4) && $past(transfer_n, 5)))
		else $error("overflow rose without transfer");
	near_sticky_a: assert property ((!near_full_n && !reset_in && !reg_wr) [*6]
		|=> !near_full_n)
		else $error("near flag dropped");
	near_clear_a: assert property (reset_in [*4] |=> ##1 near_full_n)
		else $error("near flag kept through reset");
	dots_minus_a: assert property ((char_code == DCCD_CODE_MINUS) [*4] |-> dots == 10'h030)
		else $error("minus pattern wrong");
	dots_blank_a: assert property ((char_code[3:1] == 3'h7) [*4] |-> dots == 10'h000)
		else $error("blank pattern wrong");
	dots_zero_a: assert property ((char_code == 4'h0) [*4] |-> dots == 10'h1DE)
		else $error("zero pattern wrong");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
		else $error("read data outside read slot");
endmodule
bind dccd_top dccd_monitor mon (.ref_clk, .rstn, .transfer_n, .reset_in, .digit_sel,
	.char_code, .reg_wr, .reg_rd, .reg_rdata, .bcd_out, .overflow_out, .near_full_n, .dots);
`default_nettype wire

// ---- verification/dccd_gate_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dccd_gate_model
	import dccd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic start,
	input wire logic [15:0] n,
	input wire logic [1:0] gap,
	input wire logic scan,
	input wire logic [2:0] sel_in,
	output logic count_in,
	output logic transfer_n,
	output logic reset_in,
	output logic [2:0] digit_sel,
	output logic busy
);
	logic [2:0] pos = 3'h0;
	logic [3:0] tick = 4'h0;
	initial
	begin
		count_in = 1'b0;
		transfer_n = 1'b1;
		reset_in = 1'b0;
		busy = 1'b0;
	end
	// one measurement: clear, count, transfer
	always @(posedge ref_clk)
		if (start)
		begin
			busy <= 1'b1;
			reset_in <= 1'b1;
			repeat (4) @(posedge ref_clk);
			reset_in <= 1'b0;
			repeat (n)
			begin
				count_in <= 1'b1;
				repeat (2) @(posedge ref_clk);
				count_in <= 1'b0;
				repeat (2 + gap) @(posedge ref_clk);
			end
			transfer_n <= 1'b0;
			repeat (6) @(posedge ref_clk);
			transfer_n <= 1'b1;
			repeat (6) @(posedge ref_clk);
			busy <= 1'b0;
		end
	// scanner: one position per 16 clocks, least significant first
	always @(posedge ref_clk)
	begin
		tick <= tick + 4'h1;
		if (tick == 4'hF)
			pos <= (pos == 3'h5) ? DCCD_IDX_LSD : pos + 3'h1;
	end
	assign digit_sel = scan ? pos : sel_in;
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(w, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; $display("ERROR %s exp %h got %h", w, e, g); end end
module tb
	import dccd_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic start = 1'b0;
	logic scan = 1'b0;
	logic char_right = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [1:0] gap = 2'h0;
	logic [2:0] sel_in = 3'h0;
	logic [3:0] char_code = 4'h0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] n = 16'h0000;
	logic [31:0] reg_wdata = 32'h00000000;
	logic [31:0] reg_rdata, d;
	logic [23:0] prev = 24'h000000;
	logic [9:0] de;
	logic [3:0] dexp;
	logic [3:0] bcd_out;
	logic [9:0] dots;
	logic [2:0] digit_sel;
	logic count_in, transfer_n, reset_in, busy, overflow_out, near_full_n, irq;
	int errors = 0;
	int samples_checked = 0;
	int seed = 32'h3D61;
	initial
		forever #12.5 ref_clk = !ref_clk;
	dccd_top dut (.ref_clk, .rstn, .count_in, .transfer_n, .reset_in, .digit_sel, .char_code,
		.char_right, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bcd_out,
		.overflow_out, .near_full_n, .dots, .irq);
	dccd_gate_model gate (.ref_clk, .start, .n, .gap, .scan, .sel_in, .count_in, .transfer_n,
		.reset_in, .digit_sel, .busy);
	function automatic logic [23:0] to_bcd(input int v);
		for (int i = 0; i < 6; i++)
		begin
			to_bcd[4 * i +: 4] = 4'(v % 10);
			v = v / 10;
		end
	endfunction
	// bit n is dot line n+1
	function automatic logic [9:0] dot_exp(input logic [3:0] c, input logic r);
		case (c)
			4'h0: return 10'h1DE;
			4'h1: return r ? 10'h2DD : 10'h000;
			4'h2: return r ? 10'h32E : 10'h3E3;
			4'h3: return r ? 10'h2EE : 10'h323;
			4'h4: return r ? 10'h2FC : 10'h03D;
			4'h5: return r ? 10'h1E3 : 10'h33F;
			4'h6: return r ? 10'h1E2 : 10'h1FE;
			4'h7: return r ? 10'h2DF : 10'h003;
			4'h8: return 10'h1EE;
			4'h9: return r ? 10'h1FE : 10'h12E;
			4'hC: return 10'h030;
			default: return 10'h000;
		endcase
	endfunction
	// called at a rising edge; leaves one idle cycle behind the strobe
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	// read data taken at the edge that closes its one valid cycle
	task automatic rd(input logic [3:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		d = reg_rdata;
	endtask
	task automatic wrap_up;
		$display("checked %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (70000) @(posedge ref_clk);
		errors++;
		wrap_up();
	end
	initial
	begin
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		rd(4'h2);
		`CHK("unmapped", 32'h00000000, d)
		for (int i = 0; i < 5; i++)
		begin
			gap <= 2'($random(seed));
			// at least ten counts, so the transfer follows the held-latch read
			n <= (i == 0) ? 16'h000A : (i == 1) ? 16'h03E8 :
				16'h000A + 16'($unsigned($random(seed)) % 1990);
			scan <= i[1];
			wr(DCCD_REG_MASK, {29'h0, i[0], 2'h0});
			rd(DCCD_REG_MASK);
			`CHK("mask", {29'h0, i[0], 2'h0}, d)
			rd(DCCD_REG_STATUS);
			start <= 1'b1;
			@(posedge ref_clk);
			start <= 1'b0;
			repeat (30) @(posedge ref_clk);
			rd(DCCD_REG_LATCH);
			`CHK("latch held", {8'h00, prev}, d)
			while (busy)
				@(posedge ref_clk);
			prev = to_bcd(int'(n));
			`CHK("irq", i[0], irq)
			rd(DCCD_REG_LATCH);
			`CHK("latch", {8'h00, prev}, d)
			`CHK("overflow", 1'b0, overflow_out)
			`CHK("near full", 1'b1, near_full_n)
			rd(DCCD_REG_STATUS);
			`CHK("status", 32'h00000004, d)
			repeat (2) @(posedge ref_clk);
			`CHK("irq clear", 1'b0, irq)
			scan <= 1'b0;
			for (int s = 0; s < 8; s++)
			begin
				sel_in <= 3'(s);
				repeat (4) @(posedge ref_clk);
				dexp = (s == 7) ? 4'hF : prev[4 * (s % 6) +: 4];
				`CHK("digit", dexp, bcd_out)
			end
			$display("measurement %0d done", i);
		end
		gap <= 2'h0;
		n <= 16'h0014;
		start <= 1'b1;
		@(posedge ref_clk);
		start <= 1'b0;
		repeat (24) @(posedge ref_clk);
		// clear lands between the fifth and sixth of twenty counts
		wr(DCCD_REG_CTRL, 32'h00000001);
		while (busy)
			@(posedge ref_clk);
		prev = to_bcd(15);
		rd(DCCD_REG_LATCH);
		`CHK("ctrl clear", {8'h00, prev}, d)
		$display("clear done");
		wr(DCCD_REG_LATCH, 32'h01FFFFFF);
		rd(DCCD_REG_LATCH);
		`CHK("latch read only", {8'h00, prev}, d)
		rd(DCCD_REG_MASK);
		`CHK("mask", 32'h00000000, d)
		for (int k = 0; k < 32; k++)
		begin
			char_code <= 4'(k >> 1);
			char_right <= k[0];
			repeat (4) @(posedge ref_clk);
			de = dot_exp(4'(k >> 1), k[0]);
			`CHK("dots", de, dots)
		end
		$display("decoder done");
		wrap_up();
	end
endmodule
`default_nettype wire
